// ### design/sbt_cfg.svh
// Constants for the scan and boundary test port
`ifndef SBT_CFG_SVH
`define SBT_CFG_SVH
`define SBT_CHAIN_CNT 10
`define SBT_CHAIN_LEN 8
`define SBT_SEC1_W 8
`define SBT_SEC2_W 7
`define SBT_PIN_W 15
`define SBT_IR_W 4
`define SBT_IR_BYPASS 4'hF
`define SBT_IR_CAPTURE 4'h1
`define SBT_UDR_W 8
`define SBT_SCAN_LO 2
`define SBT_SCAN_HI 6
`define SBT_SEC2_BASE 8
`endif

// ### design/sbt_pkg.sv
// Types for the scan and boundary test port
`include "sbt_cfg.svh"
package sbt_pkg;
  typedef enum logic [15:0] {
    TAP_TLR = 16'h0001,
    TAP_RTI = 16'h0002,
    TAP_SELDR = 16'h0004,
    TAP_CAPDR = 16'h0008,
    TAP_SHDR = 16'h0010,
    TAP_EX1DR = 16'h0020,
    TAP_PSDR = 16'h0040,
    TAP_EX2DR = 16'h0080,
    TAP_UPDR = 16'h0100,
    TAP_SELIR = 16'h0200,
    TAP_CAPIR = 16'h0400,
    TAP_SHIR = 16'h0800,
    TAP_EX1IR = 16'h1000,
    TAP_PSIR = 16'h2000,
    TAP_EX2IR = 16'h4000,
    TAP_UPIR = 16'h8000
  } sbt_tap_t;

  typedef logic [`SBT_CHAIN_CNT-1:0][`SBT_CHAIN_LEN-1:0] sbt_chains_t;

  typedef struct packed {
    sbt_chains_t chain;
  } sbt_chain_st_t;

  typedef struct packed {
    logic [1:0] fsN;
    logic [1:0] se;
    logic [1:0] tck;
    logic [1:0] tms;
    logic [1:0] tdi;
    logic [1:0] trstN;
    logic tckLast;
    logic [`SBT_PIN_W-1:0] reqA;
    logic [`SBT_PIN_W-1:0] reqB;
    sbt_tap_t tap;
    logic [`SBT_IR_W-1:0] ir;
    logic [`SBT_IR_W-1:0] irSh;
    logic [`SBT_UDR_W-1:0] dr;
    logic bypass;
    logic tdo;
    logic tdoOe;
    logic [`SBT_PIN_W-1:0] gnt;
    logic [`SBT_PIN_W-1:0] arbReq;
  } sbt_state_t;
endpackage

// ### design/sbt_scan_chains.sv
// Ten internal scan chains: shift or capture on the primary clock
`timescale 1ns/1ps
`include "sbt_cfg.svh"
module sbt_scan_chains (
  input wire logic clk,
  input wire logic rst,
  input wire logic scanActive,
  input wire logic scanEn,
  input wire logic [`SBT_CHAIN_CNT-1:0] scanIn,
  input wire sbt_pkg::sbt_chains_t funcNext,
  output sbt_pkg::sbt_chains_t funcState,
  output logic [`SBT_CHAIN_CNT-1:0] scanOut
);
  sbt_pkg::sbt_chain_st_t s_q;
  sbt_pkg::sbt_chain_st_t s_d;

  // ==========================================================
  // Per-chain next state
  always_comb begin
    s_d = s_q;
    for (int i = 0; i < `SBT_CHAIN_CNT; i++) begin
      if (scanActive && !scanEn) begin
        s_d.chain[i] = {s_q.chain[i][`SBT_CHAIN_LEN-2:0], scanIn[i]}; // RQ3
      end else begin
        s_d.chain[i] = funcNext[i]; // RQ4
      end
    end
  end

  // Single clock for functional and scan use, no separate scan clock
  always_ff @(posedge clk) begin // RQ2
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign funcState = s_q.chain;

  genvar g;
  generate
    for (g = 0; g < `SBT_CHAIN_CNT; g++) begin : gOut
      assign scanOut[g] = s_q.chain[g][`SBT_CHAIN_LEN-1];
    end
  endgenerate

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence sShiftCycle;
    scanActive && !scanEn;
  endsequence

  a_chain_shift_in: assert property ( // RQ3
    sShiftCycle |=> s_q.chain[0][0] == $past(scanIn[0]) &&
      s_q.chain[9][1] == $past(s_q.chain[9][0]))
    else $error("scan chain did not shift");

  a_chain_capture: assert property ( // RQ4
    !(scanActive && !scanEn) |=> s_q.chain == $past(funcNext))
    else $error("scan chain did not capture functional state");
endmodule

// ### design/sbt_test_port.sv
// Full-scan control and boundary-scan test access port
//
// Contract
// (RQ1) Active-low test mode enables ten scan chains
// (RQ2) Scan flops run on primary bus clock
// (RQ3) Scan-enable low shifts chains serially
// (RQ4) Scan-enable high captures functional next state
// (RQ5) System holds test mode high normally
// (RQ6) System holds scan-enable low normally
// (RQ7) Chain serial data uses request and grant pins
// (RQ8) Test clock times all boundary-scan transfers
// (RQ9) Test mode select steers the controller
// (RQ10) Scan-enable high: shift out on test data
// (RQ11) Scan-enable high: shift in from test data
// (RQ12) Test reset forces controller to reset state
// (RQ13) Sixteen-state controller, rise moves, fall drives
`timescale 1ns/1ps
`include "sbt_cfg.svh"
module sbt_test_port (
  input wire logic clk,
  input wire logic rst,
  input wire logic fullScanModeN,
  input wire logic scanEn,
  input wire logic [`SBT_SEC1_W-1:0] sec1BusRequestN,
  input wire logic [`SBT_SEC2_W-1:0] sec2BusRequestN,
  output logic [`SBT_SEC1_W-1:0] sec1BusGrantN,
  output logic [`SBT_SEC2_W-1:0] sec2BusGrantN,
  input wire logic [`SBT_SEC1_W-1:0] arbGrant1N,
  input wire logic [`SBT_SEC2_W-1:0] arbGrant2N,
  output logic [`SBT_SEC1_W-1:0] arbRequest1N,
  output logic [`SBT_SEC2_W-1:0] arbRequest2N,
  input wire sbt_pkg::sbt_chains_t funcNext,
  output sbt_pkg::sbt_chains_t funcState,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic trstN,
  output logic tdo,
  output logic tdoOe
);
  sbt_pkg::sbt_state_t s_q;
  sbt_pkg::sbt_state_t s_d;
  logic scanActive;
  logic tckRise;
  logic tckFall;
  logic [`SBT_CHAIN_CNT-1:0] scanIn;
  logic [`SBT_CHAIN_CNT-1:0] scanOut;

  // ==========================================================
  // Controller transitions
  function automatic sbt_pkg::sbt_tap_t tapNext(input sbt_pkg::sbt_tap_t st, input logic m);
    sbt_pkg::sbt_tap_t r;
    r = sbt_pkg::TAP_TLR;
    case (st)
      sbt_pkg::TAP_TLR: r = m ? sbt_pkg::TAP_TLR : sbt_pkg::TAP_RTI;
      sbt_pkg::TAP_RTI: r = m ? sbt_pkg::TAP_SELDR : sbt_pkg::TAP_RTI;
      sbt_pkg::TAP_SELDR: r = m ? sbt_pkg::TAP_SELIR : sbt_pkg::TAP_CAPDR;
      sbt_pkg::TAP_CAPDR: r = m ? sbt_pkg::TAP_EX1DR : sbt_pkg::TAP_SHDR;
      sbt_pkg::TAP_SHDR: r = m ? sbt_pkg::TAP_EX1DR : sbt_pkg::TAP_SHDR;
      sbt_pkg::TAP_EX1DR: r = m ? sbt_pkg::TAP_UPDR : sbt_pkg::TAP_PSDR;
      sbt_pkg::TAP_PSDR: r = m ? sbt_pkg::TAP_EX2DR : sbt_pkg::TAP_PSDR;
      sbt_pkg::TAP_EX2DR: r = m ? sbt_pkg::TAP_UPDR : sbt_pkg::TAP_SHDR;
      sbt_pkg::TAP_UPDR: r = m ? sbt_pkg::TAP_SELDR : sbt_pkg::TAP_RTI;
      sbt_pkg::TAP_SELIR: r = m ? sbt_pkg::TAP_TLR : sbt_pkg::TAP_CAPIR;
      sbt_pkg::TAP_CAPIR: r = m ? sbt_pkg::TAP_EX1IR : sbt_pkg::TAP_SHIR;
      sbt_pkg::TAP_SHIR: r = m ? sbt_pkg::TAP_EX1IR : sbt_pkg::TAP_SHIR;
      sbt_pkg::TAP_EX1IR: r = m ? sbt_pkg::TAP_UPIR : sbt_pkg::TAP_PSIR;
      sbt_pkg::TAP_PSIR: r = m ? sbt_pkg::TAP_EX2IR : sbt_pkg::TAP_PSIR;
      sbt_pkg::TAP_EX2IR: r = m ? sbt_pkg::TAP_UPIR : sbt_pkg::TAP_SHIR;
      sbt_pkg::TAP_UPIR: r = m ? sbt_pkg::TAP_SELDR : sbt_pkg::TAP_RTI;
      default: r = sbt_pkg::TAP_TLR;
    endcase
    return r;
  endfunction

  // Edges are found only on the second synchroniser stage
  assign tckRise = s_q.tck[1] && !s_q.tckLast; // RQ8
  assign tckFall = !s_q.tck[1] && s_q.tckLast; // RQ8
  assign scanActive = !s_q.fsN[1]; // RQ1

  // Serial inputs: secondary-1 then secondary-2 request pins 2..6
  assign scanIn = {s_q.reqB[`SBT_SEC2_BASE+`SBT_SCAN_HI:`SBT_SEC2_BASE+`SBT_SCAN_LO],
    s_q.reqB[`SBT_SCAN_HI:`SBT_SCAN_LO]}; // RQ7

  // ==========================================================
  // Scan chains
  sbt_scan_chains uChains (
    .clk(clk),
    .rst(rst),
    .scanActive(scanActive),
    .scanEn(s_q.se[1]),
    .scanIn(scanIn),
    .funcNext(funcNext),
    .funcState(funcState),
    .scanOut(scanOut)
  );

  // ==========================================================
  // Next state
  always_comb begin
    s_d = s_q;
    s_d.fsN = {s_q.fsN[0], fullScanModeN};
    s_d.se = {s_q.se[0], scanEn};
    s_d.tck = {s_q.tck[0], tck};
    s_d.tms = {s_q.tms[0], tms};
    s_d.tdi = {s_q.tdi[0], tdi};
    s_d.trstN = {s_q.trstN[0], trstN};
    s_d.tckLast = s_q.tck[1];
    s_d.reqA = {sec2BusRequestN, sec1BusRequestN};
    s_d.reqB = s_q.reqA;

    // Pins carry arbitration unless full-scan takes them over
    s_d.gnt = {arbGrant2N, arbGrant1N};
    s_d.arbReq = s_q.reqB;
    if (scanActive) begin
      s_d.gnt[`SBT_SCAN_HI:`SBT_SCAN_LO] = scanOut[4:0]; // RQ7
      s_d.gnt[`SBT_SEC2_BASE+`SBT_SCAN_HI:`SBT_SEC2_BASE+`SBT_SCAN_LO] = scanOut[9:5]; // RQ7
      s_d.arbReq[`SBT_SCAN_HI:`SBT_SCAN_LO] = '1;
      s_d.arbReq[`SBT_SEC2_BASE+`SBT_SCAN_HI:`SBT_SEC2_BASE+`SBT_SCAN_LO] = '1;
    end

    if (!s_q.trstN[1]) begin
      s_d.tap = sbt_pkg::TAP_TLR; // RQ12
      s_d.ir = `SBT_IR_BYPASS;
    end else if (tckRise) begin
      s_d.tap = tapNext(s_q.tap, s_q.tms[1]); // RQ9 RQ13
      case (s_q.tap)
        sbt_pkg::TAP_TLR: begin
          s_d.ir = `SBT_IR_BYPASS;
        end
        sbt_pkg::TAP_CAPDR: begin
          s_d.dr = {scanActive, s_q.se[1], scanOut[5:0]};
          s_d.bypass = 1'b0;
        end
        sbt_pkg::TAP_SHDR: begin
          // Serial test data is honoured only with scan-enable high
          if (s_q.se[1]) begin
            s_d.dr = {s_q.tdi[1], s_q.dr[`SBT_UDR_W-1:1]}; // RQ11
            s_d.bypass = s_q.tdi[1]; // RQ11
          end
        end
        sbt_pkg::TAP_CAPIR: begin
          s_d.irSh = `SBT_IR_CAPTURE;
        end
        sbt_pkg::TAP_SHIR: begin
          if (s_q.se[1]) begin
            s_d.irSh = {s_q.tdi[1], s_q.irSh[`SBT_IR_W-1:1]}; // RQ11
          end
        end
        sbt_pkg::TAP_UPIR: begin
          s_d.ir = s_q.irSh;
        end
        default: begin
        end
      endcase
    end

    if (tckFall) begin
      s_d.tdoOe = s_q.se[1] &&
        (s_q.tap == sbt_pkg::TAP_SHDR || s_q.tap == sbt_pkg::TAP_SHIR); // RQ10
      if (s_q.tap == sbt_pkg::TAP_SHIR) begin
        s_d.tdo = s_q.irSh[0]; // RQ10 RQ13
      end else if (s_q.ir == `SBT_IR_BYPASS) begin
        s_d.tdo = s_q.bypass; // RQ10 RQ13
      end else begin
        s_d.tdo = s_q.dr[0]; // RQ10 RQ13
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
      s_q.fsN <= 2'h3;
      s_q.tap <= sbt_pkg::TAP_TLR;
      s_q.ir <= `SBT_IR_BYPASS;
      s_q.reqA <= '1;
      s_q.reqB <= '1;
      s_q.gnt <= '1;
      s_q.arbReq <= '1;
    end else begin
      s_q <= s_d;
    end
  end

  assign sec1BusGrantN = s_q.gnt[`SBT_SEC1_W-1:0];
  assign sec2BusGrantN = s_q.gnt[`SBT_PIN_W-1:`SBT_SEC1_W];
  assign arbRequest1N = s_q.arbReq[`SBT_SEC1_W-1:0];
  assign arbRequest2N = s_q.arbReq[`SBT_PIN_W-1:`SBT_SEC1_W];
  assign tdo = s_q.tdo;
  assign tdoOe = s_q.tdoOe;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence sShiftDrBit;
    tckRise && s_q.trstN[1] && s_q.tap == sbt_pkg::TAP_SHDR;
  endsequence

  a_trst_forces_reset: assert property ( // RQ12
    !s_q.trstN[1] |=> s_q.tap == sbt_pkg::TAP_TLR)
    else $error("test reset did not reach reset state");

  a_tap_moves_rise: assert property ( // RQ13
    $changed(s_q.tap) |-> $past(tckRise) || !$past(s_q.trstN[1]))
    else $error("controller moved without a test clock rise");

  a_tms_steers_state: assert property ( // RQ9
    tckRise && s_q.trstN[1] && s_q.tap == sbt_pkg::TAP_RTI && s_q.tms[1]
      |=> s_q.tap == sbt_pkg::TAP_SELDR)
    else $error("test mode select not followed");

  a_tdo_on_fall: assert property ( // RQ10
    $changed(s_q.tdo) || $changed(s_q.tdoOe) |-> $past(tckFall))
    else $error("test data output changed off a falling edge");

  a_dr_shift_in: assert property ( // RQ11
    sShiftDrBit and s_q.se[1] |=> s_q.dr[`SBT_UDR_W-1] == $past(s_q.tdi[1]))
    else $error("data register did not take test data input");

  a_dr_hold_noen: assert property ( // RQ11
    sShiftDrBit and !s_q.se[1] |=> $stable(s_q.dr))
    else $error("data register shifted with scan-enable low");

  a_normal_grants: assert property ( // RQ7
    !scanActive |=> s_q.gnt == $past({arbGrant2N, arbGrant1N}))
    else $error("grant pins not carrying arbitration");

  a_scan_out_pins: assert property ( // RQ7
    scanActive ##1 scanActive |-> sec1BusGrantN[`SBT_SCAN_LO] == $past(scanOut[0]) &&
      sec2BusGrantN[`SBT_SCAN_HI] == $past(scanOut[9]))
    else $error("scan outputs missing from grant pins");
endmodule

// ### tb/sbt_tester.sv
// Test equipment model for the boundary-scan pins
`timescale 1ns/1ps
module sbt_tester (
  output logic tck,
  output logic tms,
  output logic tdi,
  output logic trstN
);
  // Test clock stands still low between frames; released lines sit at their pull-ups
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
    trstN = 1'b1;
  end

  // One 125 ns test clock period; data is held long after the fall so it can settle
  task automatic cyc(input logic m, input logic d);
    tms = m;
    tdi = d;
    #10 tck = 1'b1;
    #50 tck = 1'b0;
    #65;
  endtask

  task automatic pulse_reset();
    trstN = 1'b0;
    #100 trstN = 1'b1;
    #100;
  endtask
endmodule

// ### tb/sbt_test_port_tb.sv
// Self-checking bench for the scan and boundary test port
`timescale 1ns/1ps
`include "sbt_cfg.svh"
module sbt_test_port_tb;
  typedef struct {int kind; logic [79:0] exp;} sbt_note_t;
  logic clk, rst, fullScanModeN, scanEn, tdo, tdoOe, tck, tms, tdi, trstN;
  logic [`SBT_SEC1_W-1:0] sec1BusRequestN, sec1BusGrantN, arbGrant1N, arbRequest1N;
  logic [`SBT_SEC2_W-1:0] sec2BusRequestN, sec2BusGrantN, arbGrant2N, arbRequest2N;
  sbt_pkg::sbt_chains_t funcNext, funcState, ch;
  sbt_note_t notes[$];
  event shown;
  int errCount = 0;
  int checkCount = 0;
  logic [9:0] pat;
  logic [3:0] bits;

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  sbt_test_port i_dut (.clk(clk), .rst(rst), .fullScanModeN(fullScanModeN), .scanEn(scanEn),
    .sec1BusRequestN(sec1BusRequestN), .sec2BusRequestN(sec2BusRequestN),
    .sec1BusGrantN(sec1BusGrantN), .sec2BusGrantN(sec2BusGrantN), .arbGrant1N(arbGrant1N),
    .arbGrant2N(arbGrant2N), .arbRequest1N(arbRequest1N), .arbRequest2N(arbRequest2N),
    .funcNext(funcNext), .funcState(funcState), .tck(tck), .tms(tms), .tdi(tdi),
    .trstN(trstN), .tdo(tdo), .tdoOe(tdoOe));

  sbt_tester i_tester (.tck(tck), .tms(tms), .tdi(tdi), .trstN(trstN));

  // ==========================================
  // Scoreboard
  task automatic cmp(string name, logic [79:0] e, logic [79:0] s);
    checkCount++;
    if (s !== e) begin
      errCount++;
      $display("[FAIL] %s expected %h seen %h", name, e, s);
    end
  endtask
  task automatic chk_grant(logic [79:0] e);
    cmp("grants", e, {65'h0, sec2BusGrantN, sec1BusGrantN});
  endtask
  task automatic chk_pins(logic [79:0] e);
    cmp("scan_out_pins", e, {70'h0, sec2BusGrantN[6:2], sec1BusGrantN[6:2]});
  endtask
  task automatic chk_chain(logic [79:0] e);
    cmp("chains", e, funcState);
  endtask
  task automatic chk_tdo(logic [79:0] e);
    cmp("tdo_oe_tdo", e, {78'h0, tdoOe, tdo});
  endtask
  task automatic chk_req(logic [79:0] e);
    cmp("arb_requests", e, {65'h0, arbRequest2N, arbRequest1N});
  endtask

  initial begin
    sbt_note_t n;
    forever begin
      @(shown);
      // Drain every note: several may be posted in one time step
      while (notes.size() > 0) begin
        n = notes.pop_front();
        case (n.kind)
          0: chk_grant(n.exp);
          1: chk_pins(n.exp);
          2: chk_chain(n.exp);
          3: chk_tdo(n.exp);
          default: chk_req(n.exp);
        endcase
      end
    end
  end

  // All outputs are registered, so notes are compared in the step they are posted
  task automatic expect_res(int kind, logic [79:0] e);
    notes.push_back('{kind, e});
    -> shown;
  endtask

  task automatic step(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic walk(logic [15:0] seq, int n);
    for (int i = 0; i < n; i++) i_tester.cyc(seq[i], 1'b1);
  endtask

  task automatic shift(logic [3:0] din, logic [3:0] dexp);
    for (int i = 0; i < 4; i++) begin
      expect_res(3, {78'h0, 1'b1, dexp[i]});
      i_tester.cyc(i == 3, din[i]);
    end
  endtask

  task automatic completeRun();
    $display("checks %0d errors %0d", checkCount, errCount);
    if (errCount == 0 && checkCount > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // The tests take about 6 us; the limit leaves ample margin
  initial begin
    #200000;
    errCount++;
    completeRun();
  end

  // ==========================================
  // Scenarios
  initial begin
    rst = 1'b1;
    fullScanModeN = 1'b1;
    scanEn = 1'b0;
    sec1BusRequestN = '1;
    sec2BusRequestN = '1;
    arbGrant1N = '1;
    arbGrant2N = '1;
    funcNext = '0;
    pat = 10'($urandom(32'h89C81835));
    step(3);
    expect_res(0, 80'h7FFF);
    expect_res(2, 80'h0);
    expect_res(3, 80'h0);
    rst = 1'b0;
    step(1);
    {arbGrant2N, arbGrant1N} = 15'($urandom);
    {sec2BusRequestN, sec1BusRequestN} = 15'($urandom);
    step(4);
    expect_res(0, {65'h0, arbGrant2N, arbGrant1N});
    expect_res(4, {65'h0, sec2BusRequestN, sec1BusRequestN});
    expect_res(2, 80'h0);
    step(1);
    fullScanModeN = 1'b0;
    {sec2BusRequestN[6:2], sec1BusRequestN[6:2]} = pat;
    step(14);
    expect_res(1, {70'h0, pat});
    expect_res(4, {65'h0, sec2BusRequestN | 7'h7C, sec1BusRequestN | 8'h7C});
    for (int i = 0; i < 10; i++) ch[i] = {8{pat[i]}};
    expect_res(2, ch);
    // Three inverted bits behind five old ones prove the shift direction
    {sec2BusRequestN[6:2], sec1BusRequestN[6:2]} = ~pat;
    step(5);
    for (int i = 0; i < 10; i++) ch[i] = {{5{pat[i]}}, {3{~pat[i]}}};
    expect_res(2, ch);
    scanEn = 1'b1;
    funcNext = 80'({$urandom, $urandom, $urandom});
    step(5);
    expect_res(2, funcNext);
    fullScanModeN = 1'b1;
    step(4);
    walk(16'h00DF, 10);
    shift(4'h0, 4'h1);
    walk(16'h0001, 2);
    // Instruction 0 selects the status register: chain outputs 0..3 come out first
    walk(16'h0001, 3);
    bits = {funcNext[3][7], funcNext[2][7], funcNext[1][7], funcNext[0][7]};
    shift(4'($urandom), bits);
    walk(16'h0001, 2);
    i_tester.pulse_reset();
    walk(16'h0002, 4);
    bits = 4'($urandom);
    shift(bits, {bits[2:0], 1'b0});
    walk(16'h0001, 2);
    // With scan-enable low the shift path is refused: no drive and no shift
    scanEn = 1'b0;
    step(3);
    walk(16'h0001, 3);
    expect_res(3, 80'h0);
    i_tester.cyc(1'b0, 1'b1);
    expect_res(3, 80'h0);
    walk(16'h0003, 3);
    step(4);
    completeRun();
  end
endmodule
